// file: logic/acmp_pkg.sv
// constants shared by the comparator control block
`default_nettype none
package acmp_pkg;
  localparam int unsigned NUM_CMP = 3;
  localparam int unsigned LVL_W = 12;
  localparam int unsigned TAP_W = 4;
  localparam logic [LVL_W-1:0] LVL_FULL = 12'hfff;
  localparam logic [4:0] LADDER_RNG0 = 5'h1f;
  localparam logic [4:0] LADDER_RNG1 = 5'h17;
  localparam logic [4:0] TAP_OFFSET_RNG0 = 5'h08;
  localparam logic [1:0] SRC_OWN_A = 2'h0;
  localparam logic [1:0] SRC_OWN_B = 2'h1;
  localparam logic [1:0] SRC_REF = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam logic [LVL_W-1:0] LVL_RST = 12'h000;
  localparam logic RES_RST = 1'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
endpackage : acmp_pkg
`default_nettype wire

// file: logic/acmp_channel.sv
// one comparator: pin synchronisers, positive source mux, compare, change event
`timescale 1ns/1ps
`default_nettype none
module acmp_channel #(
  parameter bit IS_FIRST = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [acmp_pkg::LVL_W-1:0] neg_pin,
  input wire logic [acmp_pkg::LVL_W-1:0] pos_pin,
  input wire logic [acmp_pkg::LVL_W-1:0] c0_pos_lvl,
  input wire logic [acmp_pkg::LVL_W-1:0] ref_lvl,
  input wire logic [1:0] src_sel,
  output logic [acmp_pkg::LVL_W-1:0] pos_lvl,
  output logic result,
  output logic change
);
  // ******************************
  // pin synchronisers
  // ******************************
  logic [acmp_pkg::LVL_W-1:0] neg_s1_ff, neg_s2_ff, pos_s1_ff, pos_s2_ff;
  logic result_ff, prev_ff, nxt_result;
  logic [acmp_pkg::LVL_W-1:0] sel_lvl;

  always_ff @(posedge clk) begin
    if (reset) begin
      neg_s1_ff <= acmp_pkg::LVL_RST;
      neg_s2_ff <= acmp_pkg::LVL_RST;
      pos_s1_ff <= acmp_pkg::LVL_RST;
      pos_s2_ff <= acmp_pkg::LVL_RST;
    end else begin
      neg_s1_ff <= neg_pin;
      neg_s2_ff <= neg_s1_ff;
      pos_s1_ff <= pos_pin;
      pos_s2_ff <= pos_s1_ff;
    end
  end

  assign pos_lvl = pos_s2_ff;

  // ******************************
  // source select and compare
  // ******************************
  always_comb begin
    case (src_sel)
      acmp_pkg::SRC_OWN_A: sel_lvl = pos_s2_ff;
      acmp_pkg::SRC_OWN_B: sel_lvl = IS_FIRST ? pos_s2_ff : c0_pos_lvl;
      acmp_pkg::SRC_REF: sel_lvl = ref_lvl;
      // reserved code compares against ground so the output stays quiet
      default: sel_lvl = acmp_pkg::LVL_RST;
    endcase
    nxt_result = neg_s2_ff < sel_lvl;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_ff <= acmp_pkg::RES_RST;
      prev_ff <= acmp_pkg::RES_RST;
    end else begin
      result_ff <= nxt_result;
      prev_ff <= result_ff;
    end
  end

  assign result = result_ff;
  assign change = result_ff ^ prev_ff;

  // ******************************
  // checks
  // ******************************
  property p_cmp_high;
    @(posedge clk) disable iff (reset) (neg_s2_ff < sel_lvl) |=> result_ff;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("result not high");

  property p_cmp_low;
    @(posedge clk) disable iff (reset) (neg_s2_ff > sel_lvl) |=> !result_ff;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("result not low");

  property p_src_ref;
    @(posedge clk) disable iff (reset)
      (src_sel == acmp_pkg::SRC_REF && ref_lvl > neg_s2_ff) |=> result_ff;
  endproperty
  a_src_ref: assert property (p_src_ref) else $error("reference not routed");
endmodule : acmp_channel
`default_nettype wire

// file: logic/acmp_top.sv
// comparator control: reference ladder, three channels, pin outputs, interrupts
`timescale 1ns/1ps
`default_nettype none
module acmp_top #(
  parameter int unsigned NCMP = acmp_pkg::NUM_CMP
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [acmp_pkg::LVL_W-1:0] CMP_NEG_PIN [NCMP],
  input wire logic [acmp_pkg::LVL_W-1:0] CMP_POS_PIN [NCMP],
  input wire logic [1:0] POSITIVE_SOURCE_SELECT [NCMP],
  input wire logic [NCMP-1:0] OUT_INVERT,
  input wire logic REF_ENABLE,
  input wire logic REF_RANGE_SELECT,
  input wire logic [acmp_pkg::TAP_W-1:0] REF_TAP,
  input wire logic [NCMP-1:0] IRQ_ENABLE,
  input wire logic [NCMP-1:0] IRQ_CLEAR,
  output logic [NCMP-1:0] RESULT_VALUE,
  output logic [NCMP-1:0] CMP_OUT_PIN,
  output logic [NCMP-1:0] CMP_OUT_PIN_OE,
  output logic [NCMP-1:0] RAW_IRQ_STATUS,
  output logic [NCMP-1:0] MASKED_IRQ_STATUS,
  output logic IRQ
);
  // ******************************
  // internal reference ladder
  // ******************************
  logic [acmp_pkg::LVL_W-1:0] ref_ff, nxt_ref;
  logic [4:0] tap_pos;
  logic [16:0] ref_num;

  always_comb begin
    tap_pos = 5'(REF_TAP);
    if (!REF_RANGE_SELECT) begin
      tap_pos = 5'(REF_TAP) + acmp_pkg::TAP_OFFSET_RNG0;
    end
    ref_num = 17'(tap_pos) * 17'(acmp_pkg::LVL_FULL);
    if (!REF_ENABLE) begin
      nxt_ref = acmp_pkg::LVL_RST;
    end else if (REF_RANGE_SELECT) begin
      nxt_ref = acmp_pkg::LVL_W'(ref_num / 17'(acmp_pkg::LADDER_RNG1));
    end else begin
      nxt_ref = acmp_pkg::LVL_W'(ref_num / 17'(acmp_pkg::LADDER_RNG0));
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ref_ff <= acmp_pkg::LVL_RST;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  // ******************************
  // comparators
  // ******************************
  logic [acmp_pkg::LVL_W-1:0] pos_lvl [NCMP];
  logic [NCMP-1:0] result, change;

  for (genvar i = 0; i < NCMP; i++) begin : g_cmp
    acmp_channel #(.IS_FIRST(i == 0)) u_chan (
      .clk(CLK),
      .reset(RESET),
      .neg_pin(CMP_NEG_PIN[i]),
      .pos_pin(CMP_POS_PIN[i]),
      .c0_pos_lvl(pos_lvl[0]),
      .ref_lvl(ref_ff),
      .src_sel(POSITIVE_SOURCE_SELECT[i]),
      .pos_lvl(pos_lvl[i]),
      .result(result[i]),
      .change(change[i])
    );
  end

  assign RESULT_VALUE = result;

  // ******************************
  // pin outputs
  // ******************************
  logic [NCMP-1:0] out_ff, nxt_out, oe_ff, nxt_oe;

  always_comb begin
    nxt_out = result ^ OUT_INVERT;
    for (int i = 0; i < NCMP; i++) begin
      // shared pins of the later comparators are inputs while own source is picked
      nxt_oe[i] = (i == 0) || (POSITIVE_SOURCE_SELECT[i] != acmp_pkg::SRC_OWN_A);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      out_ff <= '0;
      oe_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign CMP_OUT_PIN = out_ff;
  assign CMP_OUT_PIN_OE = oe_ff;

  // ******************************
  // interrupt status
  // ******************************
  logic [NCMP-1:0] raw_ff, nxt_raw;

  always_comb begin
    // a change in the clearing cycle survives: set beats clear
    nxt_raw = (raw_ff & ~(IRQ_CLEAR & IRQ_ENABLE)) | change;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      raw_ff <= NCMP'(acmp_pkg::IRQ_RST);
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  assign RAW_IRQ_STATUS = raw_ff;
  assign MASKED_IRQ_STATUS = raw_ff & IRQ_ENABLE;
  assign IRQ = |(raw_ff & IRQ_ENABLE);

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_ref_gnd;
    !REF_ENABLE |=> ref_ff == acmp_pkg::LVL_RST;
  endproperty
  a_ref_gnd: assert property (p_ref_gnd) else $error("reference not ground");

  property p_ref_rng0;
    (REF_ENABLE && !REF_RANGE_SELECT && REF_TAP == 4'h0) |=> ref_ff == 12'h420;
  endproperty
  a_ref_rng0: assert property (p_ref_rng0) else $error("range 0 tap wrong");

  property p_ref_rng1;
    (REF_ENABLE && REF_RANGE_SELECT && REF_TAP == 4'h1) |=> ref_ff == 12'h0b2;
  endproperty
  a_ref_rng1: assert property (p_ref_rng1) else $error("range 1 tap wrong");

  property p_irq_or;
    IRQ == |MASKED_IRQ_STATUS;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("interrupt not or of masked");

  property p_masked_gate;
    MASKED_IRQ_STATUS == (RAW_IRQ_STATUS & IRQ_ENABLE);
  endproperty
  a_masked_gate: assert property (p_masked_gate) else $error("masked bits wrong");

  // ladder high taps: integer division truncates, so range 0 tap 14 and range 1 tap 15 land just below
  property p_ref_high_tap;
    (REF_ENABLE && !REF_RANGE_SELECT && REF_TAP == 4'he) |=> ref_ff == 12'hb5a;
  endproperty
  a_ref_high_tap: assert property (p_ref_high_tap) else $error("range 0 high tap wrong");

  property p_ref_range1_top;
    (REF_ENABLE && REF_RANGE_SELECT && REF_TAP == 4'hf) |=> ref_ff == 12'ha6e;
  endproperty
  a_ref_range1_top: assert property (p_ref_range1_top) else $error("range 1 top tap wrong");

  property p_irq_off;
    (IRQ_ENABLE == '0) |-> !IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without enable");

  for (genvar i = 0; i < NCMP; i++) begin : g_chk
    sequence s_cleared;
      IRQ_CLEAR[i] && IRQ_ENABLE[i] && !change[i];
    endsequence
    property p_raw_set;
      change[i] |=> RAW_IRQ_STATUS[i];
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("raw bit not set");
    property p_clear;
      s_cleared |=> !RAW_IRQ_STATUS[i];
    endproperty
    a_clear: assert property (p_clear) else $error("bit not cleared");
    property p_hold;
      (RAW_IRQ_STATUS[i] && !IRQ_CLEAR[i]) |=> RAW_IRQ_STATUS[i];
    endproperty
    a_hold: assert property (p_hold) else $error("raw bit lost");
    property p_invert;
      1'b1 |=> CMP_OUT_PIN[i] == ($past(result[i]) ^ $past(OUT_INVERT[i]));
    endproperty
    a_invert: assert property (p_invert) else $error("pin polarity wrong");
    // later comparators share their pin with the positive input
    property p_pin_drive;
      1'b1 |=> CMP_OUT_PIN_OE[i] ==
        ((i == 0) || ($past(POSITIVE_SOURCE_SELECT[i]) != acmp_pkg::SRC_OWN_A));
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong");
  end
endmodule : acmp_top
`default_nettype wire

// file: sim/test_acmp_top.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module test_acmp_top;
  logic clk;
  logic reset;
  logic [acmp_pkg::LVL_W-1:0] neg [3];
  logic [acmp_pkg::LVL_W-1:0] pos [3];
  logic [1:0] sel [3];
  logic [2:0] inv;
  logic ref_en;
  logic ref_range_sel;
  logic [acmp_pkg::TAP_W-1:0] ref_tap;
  logic [2:0] irq_en;
  logic [2:0] irq_clr;
  logic [2:0] res;
  logic [2:0] out_pin;
  logic [2:0] out_oe;
  logic [2:0] raw;
  logic [2:0] masked;
  logic irq;
  int failures;
  int tests_run;
  int cycles;
  int lvl;

  acmp_top dut_u (.CLK(clk), .RESET(reset), .CMP_NEG_PIN(neg), .CMP_POS_PIN(pos),
    .POSITIVE_SOURCE_SELECT(sel), .OUT_INVERT(inv), .REF_ENABLE(ref_en),
    .REF_RANGE_SELECT(ref_range_sel), .REF_TAP(ref_tap), .IRQ_ENABLE(irq_en),
    .IRQ_CLEAR(irq_clr),
    .RESULT_VALUE(res), .CMP_OUT_PIN(out_pin), .CMP_OUT_PIN_OE(out_oe),
    .RAW_IRQ_STATUS(raw), .MASKED_IRQ_STATUS(masked), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // pins pass two synchronisers and a result register, so six edges is settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // hang guard well above the 159 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    failures = 0;
    tests_run = 0;
    cycles = 0;
    reset = 1'b1;
    for (int i = 0; i < 3; i++) begin
      neg[i] = 12'hfff;
      pos[i] = 12'h000;
      sel[i] = acmp_pkg::SRC_OWN_A;
    end
    inv = 3'h2;
    ref_en = 1'b0;
    ref_range_sel = 1'b0;
    ref_tap = 4'h0;
    irq_en = 3'h0;
    irq_clr = 3'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("irq in reset", {raw, masked, irq}, 12'h000);
    reset = 1'b0; // clock already running before first use
    settle(6);
    for (int i = 0; i < 3; i++) begin
      neg[i] = 12'h100;
      pos[i] = 12'h800;
      settle(6);
      check("result low neg", res[i], 1'b1);
      check("raw set", raw[i], 1'b1);
      check("masked off", {masked[i], irq}, 2'h0);
      check("out pin", out_pin[i], 1'b1 ^ inv[i]);
      check("pin drive", out_oe[i], i == 0);
      irq_en[i] = 1'b1;
      settle(1);
      check("masked on", {masked[i], irq}, 2'h3);
      irq_clr[i] = 1'b1;
      settle(0);
      irq_clr[i] = 1'b0;
      settle(1);
      check("cleared", {raw[i], masked[i], irq}, 3'h0);
      neg[i] = 12'hfff;
      settle(6);
      check("result high neg", {res[i], raw[i], irq}, 3'h3);
      irq_en[i] = 1'b0;
      irq_clr[i] = 1'b1;
      settle(1);
      irq_clr[i] = 1'b0;
      check("clear masked off", {raw[i], masked[i], irq}, 3'h4);
    end
    $display("test compare done");
    pos[0] = 12'h800;
    pos[1] = 12'h000;
    pos[2] = 12'h000;
    for (int i = 0; i < 3; i++) begin
      neg[i] = 12'h100;
      sel[i] = acmp_pkg::SRC_OWN_B;
    end
    settle(6);
    check("source code 01", res, 3'h7);
    check("pin drive sel", out_oe, 3'h7);
    inv = 3'h5;
    settle(1);
    check("inverted pins", out_pin, 3'h2);
    for (int i = 0; i < 3; i++) sel[i] = acmp_pkg::SRC_RSVD;
    settle(6);
    check("reserved code", res, 3'h0);
    $display("test sources done");
    for (int i = 0; i < 3; i++) sel[i] = acmp_pkg::SRC_REF;
    ref_en = 1'b1;
    for (int r = 0; r < 2; r++) begin
      for (int t = r; t < 16; t += 7) begin
        ref_range_sel = r[0];
        ref_tap = t[3:0];
        lvl = (r == 1) ? t * 4095 / 23 : (t + 8) * 4095 / 31;
        for (int i = 0; i < 3; i++) neg[i] = 12'(lvl - 1);
        settle(6);
        check("below tap", res, 3'h7);
        for (int i = 0; i < 3; i++) neg[i] = 12'(lvl + 1);
        settle(6);
        check("above tap", res, 3'h0);
      end
    end
    // example setting: range 1, tap 12, comparator 0 pin not inverted
    inv = 3'h0;
    ref_range_sel = 1'b1;
    ref_tap = 4'hc;
    lvl = 12 * 4095 / 23;
    neg[0] = 12'(lvl - 1);
    settle(6);
    check("example result", res, 3'h1);
    check("example pin", out_pin[0], 1'b1);
    ref_en = 1'b0;
    ref_range_sel = 1'b0;
    ref_tap = 4'hf;
    for (int i = 0; i < 3; i++) neg[i] = 12'h010;
    settle(6);
    check("reference off", res, 3'h0);
    $display("test reference done");
    give_verdict();
  end
endmodule : test_acmp_top
`default_nettype wire
